// ==== design/mas_pkg.sv ====
// constants and carrier types of the microprogram address sequencer
package mas_pkg;
  // ********************
  // sizes
  // ********************
  localparam int ADR_W     = 11;
  localparam int DISP_W    = 5;
  localparam int DISP_WORDS = 1280;
  localparam int DTAB_WORDS = 512;
  localparam int STACK_D   = 4;
  localparam int COND_W    = 6;
  localparam int BUS_AW    = 8;
  localparam int BUS_DW    = 16;

  // ********************
  // register offsets (diagnostic function codes and own)
  // ********************
  localparam logic [7:0] OFS_DIAG_A   = 8'h29; // function 051
  localparam logic [7:0] OFS_DIAG_B   = 8'h2a; // function 052
  localparam logic [7:0] OFS_PAR_EN   = 8'h24; // function 044
  localparam logic [7:0] OFS_DSTORE   = 8'h40;
  localparam logic [7:0] OFS_DTAB     = 8'h41;
  localparam logic [7:0] OFS_STATUS   = 8'h44;
  localparam logic [7:0] OFS_ADDR     = 8'h45;

  // ********************
  // dispatch codes and field positions
  // ********************
  localparam logic [4:0] DISP_DIAG    = 5'h00;
  localparam logic [4:0] DISP_FETCH   = 5'h02;
  localparam logic [4:0] DISP_MUL     = 5'h1c;
  localparam logic [4:0] DISP_EAMOD   = 5'h1e; // octal 36
  localparam logic [1:0] SKIP_HI      = 2'h3;  // codes octal 60-77
  localparam logic [10:0] FETCH_BASE  = 11'h020; // octal 40
  localparam int DTAB_J_LSB = 0;
  localparam int DTAB_A_LSB = 11;
  localparam int STAT_STOP  = 12;
  localparam int STAT_PERR  = 11;
  localparam logic [15:0] RST_RDATA   = 16'h0000;

  // ********************
  // carrier types
  // ********************
  typedef struct packed {
    logic [10:0] jump;
    logic [5:0]  cond;
    logic        call;
    logic        ret;
    logic        par;
  } mas_word_t;

  typedef struct packed {
    logic ext_bit13;
    logic index_nonzero;
    logic exp_sign;
    logic multiplier_quotient_bit_34;
    logic mq35;
    logic skip_true;
  } mas_cond_t;

  typedef struct packed {
    logic [2:0]  acc;
    logic [10:0] jump;
  } mas_dtab_t;

  typedef enum logic [1:0] {
    MAS_RUN   = 2'b01,
    MAS_FORCE = 2'b10
  } mas_state_t;
endpackage : mas_pkg

// ==== design/mas_top.sv ====
// next-address sequencer: dispatch store, diagnostic address, stack, parity
`timescale 1ns/1ps
// Operation
// R1: local dispatch store of 1280 five-bit words.
// R2: diagnostic address register addresses every control store word.
// R3: master reset clears microword; zero dispatch selects diagnostic address.
// R4: diagnostic codes 051 and 052 load the diagnostic address from bus.
// R5: each address line is an OR of its inputs.
// R6: address modified in groups 00-06, 07-10, 08-10 and 10.
// R7: effective address dispatch ORs bit13 into 09, indexed into 10.
// R8: page fail forces bits 01-10 to ones, bit 00 untouched.
// R9: forced address gets exactly one load clock, then normal run.
// R10: page fail also forces a subroutine push.
// R11: skip sets bit 10 only for codes 60-77 with true condition.
// R12: multiply dispatch uses exponent sign and quotient bits 34, 35.
// R13: sign false exits via bit 08 and forces 09, 10.
// R14: access bits 00,01 zero: fetch outputs copy table jump bits.
// R15: access bit set: fetch outputs give 40 plus access type.
// R16: fetch outputs selected only with dispatch code 2.
// R17: dispatch parity computed except in reset; combined parity odd.
// R18: parity check enabled: error stops clocks on next clock.
// R19: reset forces dispatch parity to read odd.
// R20: instruction dispatch table holds 512 words of type and index.
// R21: return stack four deep, 11 wide, push on call, pop on return.
// R22: return address is popped entry ORed with jump field.
// R23: with nothing active each line follows the jump field.
module mas_top (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic [7:0]                bus_addr,
  input  wire logic [15:0]               bus_wdata,
  input  wire logic                      bus_wr,
  input  wire logic                      bus_rd,
  output      logic [15:0]               bus_rdata,
  input  wire logic                      clock_advance,
  input  wire logic                      page_fail,
  input  wire logic [8:0]                opcode,
  input  wire mas_pkg::mas_word_t        store_word,
  input  wire mas_pkg::mas_cond_t        cond_in,
  output      logic [0:10]               microaddress_lines,
  output      logic                      microword_load_clock,
  output      logic                      forced_subroutine_push,
  output      logic                      reset_parity_override,
  output      logic                      dispatch_parity,
  output      logic                      parity_error,
  output      logic                      clocks_stopped
);
  // ********************
  // state
  // ********************
  mas_pkg::mas_state_t st_reg, st_next;
  mas_pkg::mas_word_t  uw_reg, uw_next;
  logic [4:0]          dsp_reg, dsp_next;
  logic [10:0]         diag_reg, diag_next;
  logic [10:0]         loc_reg, loc_next;
  logic [10:0]         stk_reg [mas_pkg::STACK_D];
  logic [10:0]         stk_next [mas_pkg::STACK_D];
  logic                pen_reg, pen_next;
  logic                stop_reg, stop_next;
  logic [15:0]         rd_reg, rd_next;
  logic [4:0]          dstore [mas_pkg::DISP_WORDS];
  mas_pkg::mas_dtab_t  dtab [mas_pkg::DTAB_WORDS];
  logic [10:0]         addr;
  logic [10:0]         fetch;
  logic                load, push, skip10, multiply_exit_force, ds_we, dt_we;
  logic [4:0]          ds_rd;
  mas_pkg::mas_dtab_t  dt_rd;

  // ********************
  // storage
  // ********************
  // R1: dispatch store write
  assign ds_we = bus_wr && bus_addr == mas_pkg::OFS_DSTORE
                 && diag_reg < 11'(mas_pkg::DISP_WORDS);
  // R20: dispatch table write
  assign dt_we = bus_wr && bus_addr == mas_pkg::OFS_DTAB;
  always_ff @(posedge mclk) begin
    if (ds_we) begin
      dstore[diag_reg] <= bus_wdata[4:0];
    end
    if (dt_we) begin
      dtab[diag_reg[8:0]] <= mas_pkg::mas_dtab_t'(bus_wdata[13:0]);
    end
  end
  // words above the store read as zero dispatch
  assign ds_rd = (addr < 11'(mas_pkg::DISP_WORDS)) ? dstore[addr] : 5'h00;
  assign dt_rd = dtab[opcode];

  // ********************
  // address gates
  // ********************
  // R11: skip only for codes 60-77
  assign skip10 = uw_reg.cond[5:4] == mas_pkg::SKIP_HI && cond_in.skip_true;
  // R13: exit forces 09 and 10
  assign multiply_exit_force = dsp_reg == mas_pkg::DISP_MUL && !cond_in.exp_sign;

  always_comb begin
    // R14: copy of table jump bits 01-04 and 07-10, bits 00, 05 and 06 cleared
    fetch = dt_rd.jump & 11'h3cf;
    // R15: access type present
    if (dt_rd.acc[2] || dt_rd.acc[1]) begin
      fetch = mas_pkg::FETCH_BASE + {8'h00, dt_rd.acc};
    end
  end

  always_comb begin
    // R23: jump field by default
    addr = uw_reg.jump;
    case (dsp_reg)
      // R3: zero dispatch picks diagnostic address
      mas_pkg::DISP_DIAG: addr = diag_reg;
      // R16: fetch mixers on code 2
      mas_pkg::DISP_FETCH: addr = uw_reg.jump | fetch;
      // R7: effective address modify
      mas_pkg::DISP_EAMOD: begin
        addr[1] = uw_reg.jump[1] | cond_in.ext_bit13;
        addr[0] = uw_reg.jump[0] | cond_in.index_nonzero;
      end
      // R12: multiply loop branch
      mas_pkg::DISP_MUL: begin
        addr[2] = uw_reg.jump[2] | multiply_exit_force;
        addr[1] = uw_reg.jump[1] | cond_in.multiplier_quotient_bit_34 | multiply_exit_force;
        addr[0] = uw_reg.jump[0] | cond_in.mq35 | multiply_exit_force;
      end
      default: addr = uw_reg.jump;
    endcase
    // R22: return ORs popped entry
    if (uw_reg.ret) begin
      addr = addr | stk_reg[0];
    end
    // R5: skip ORs into bit 10
    addr[0] = addr[0] | skip10;
    // R8: page fail leaves bit 00 alone
    if (st_reg == mas_pkg::MAS_FORCE) begin
      addr[9:0] = 10'h3ff;
    end
  end
  // R6: lines numbered 00 at the top
  assign microaddress_lines = addr;

  // ********************
  // sequencing
  // ********************
  always_comb begin
    st_next = st_reg;
    load    = 1'b0;
    case (st_reg)
      mas_pkg::MAS_RUN: begin
        if (page_fail && !stop_reg) begin
          st_next = mas_pkg::MAS_FORCE;
        end else begin
          load = clock_advance && !stop_reg;
        end
      end
      // R9: single load on forced address
      mas_pkg::MAS_FORCE: begin
        load    = 1'b1;
        st_next = mas_pkg::MAS_RUN;
      end
      default: st_next = mas_pkg::MAS_RUN;
    endcase
  end
  assign microword_load_clock = load;
  // R10: forced push with page fail
  assign forced_subroutine_push = st_reg == mas_pkg::MAS_FORCE;
  assign push = load && (uw_reg.call || forced_subroutine_push);

  always_comb begin
    uw_next  = uw_reg;
    dsp_next = dsp_reg;
    loc_next = loc_reg;
    stk_next = stk_reg;
    if (load) begin
      uw_next  = store_word;
      dsp_next = ds_rd;
      loc_next = addr;
      // R21: shift stack
      if (push) begin
        for (int i = mas_pkg::STACK_D - 1; i > 0; i--) begin
          stk_next[i] = stk_reg[i-1];
        end
        stk_next[0] = loc_reg;
      end else if (uw_reg.ret) begin
        for (int i = 0; i < mas_pkg::STACK_D - 1; i++) begin
          stk_next[i] = stk_reg[i+1];
        end
        stk_next[mas_pkg::STACK_D-1] = 11'h000;
      end
    end
  end

  // ********************
  // parity
  // ********************
  // R19: override while reset held
  assign reset_parity_override = !rst_n;
  // R17: odd parity of dispatch bits
  assign dispatch_parity = reset_parity_override ? 1'b1 : ~^dsp_reg;
  assign parity_error = !(dispatch_parity ^ uw_reg.par);

  // ********************
  // register port
  // ********************
  always_comb begin
    diag_next = diag_reg;
    pen_next  = pen_reg;
    // R18: stop on next clock
    stop_next = stop_reg | (pen_reg && parity_error);
    rd_next   = mas_pkg::RST_RDATA;
    if (bus_wr) begin
      case (bus_addr)
        // R4: both codes load the address
        mas_pkg::OFS_DIAG_A,
        mas_pkg::OFS_DIAG_B: diag_next = bus_wdata[10:0];
        mas_pkg::OFS_PAR_EN: begin
          pen_next  = bus_wdata[0];
          // a new error outranks a clear in the same cycle
          stop_next = (stop_reg & ~bus_wdata[1]) | (pen_reg && parity_error);
        end
        default: diag_next = diag_reg;
      endcase
    end
    if (bus_rd) begin
      case (bus_addr)
        // R2: both codes read back the diagnostic address
        mas_pkg::OFS_DIAG_A,
        mas_pkg::OFS_DIAG_B: rd_next = {5'h00, diag_reg};
        mas_pkg::OFS_PAR_EN: rd_next = {15'h0000, pen_reg};
        mas_pkg::OFS_DSTORE: rd_next = (diag_reg < 11'(mas_pkg::DISP_WORDS))
                                       ? {11'h000, dstore[diag_reg]} : 16'h0000;
        mas_pkg::OFS_DTAB:   rd_next = {2'h0, dtab[diag_reg[8:0]]};
        mas_pkg::OFS_STATUS: rd_next = {3'h0, stop_reg, parity_error, loc_reg};
        mas_pkg::OFS_ADDR:   rd_next = {5'h00, addr};
        default:             rd_next = mas_pkg::RST_RDATA;
      endcase
    end
  end
  assign bus_rdata = rd_reg;
  assign clocks_stopped = stop_reg;

  // ********************
  // registers
  // ********************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg   <= mas_pkg::MAS_RUN;
      // R3: microword cleared
      uw_reg   <= '0;
      dsp_reg  <= 5'h00;
      diag_reg <= 11'h000;
      loc_reg  <= 11'h000;
      stk_reg  <= '{default: 11'h000};
      pen_reg  <= 1'b0;
      stop_reg <= 1'b0;
      rd_reg   <= mas_pkg::RST_RDATA;
    end else begin
      st_reg   <= st_next;
      uw_reg   <= uw_next;
      dsp_reg  <= dsp_next;
      diag_reg <= diag_next;
      loc_reg  <= loc_next;
      stk_reg  <= stk_next;
      pen_reg  <= pen_next;
      stop_reg <= stop_next;
      rd_reg   <= rd_next;
    end
  end

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_diag_sel;
    st_reg == mas_pkg::MAS_RUN && dsp_reg == mas_pkg::DISP_DIAG && !uw_reg.ret
      && !skip10 |-> addr == diag_reg;
  endproperty
  a_diag_sel: assert property (p_diag_sel) else $error("diag address not selected"); // R3

  property p_diag_load;
    bus_wr && bus_addr == mas_pkg::OFS_DIAG_B |=> diag_reg == $past(bus_wdata[10:0]);
  endproperty
  a_diag_load: assert property (p_diag_load) else $error("diag load lost"); // R4

  property p_force;
    st_reg == mas_pkg::MAS_FORCE |-> addr[9:0] == 10'h3ff && forced_subroutine_push;
  endproperty
  a_force: assert property (p_force) else $error("page fail address wrong"); // R8

  sequence s_fail_taken;
    st_reg == mas_pkg::MAS_RUN && page_fail && !stop_reg;
  endsequence
  sequence s_one_load;
    microword_load_clock && push ##1 st_reg == mas_pkg::MAS_RUN;
  endsequence
  property p_one_load;
    s_fail_taken |=> s_one_load;
  endproperty
  a_one_load: assert property (p_one_load) else $error("forced load not single"); // R9

  property p_skip;
    uw_reg.cond[5:4] != mas_pkg::SKIP_HI |-> !skip10;
  endproperty
  a_skip: assert property (p_skip) else $error("skip outside range"); // R11

  property p_mul_exit;
    st_reg == mas_pkg::MAS_RUN && multiply_exit_force |-> addr[2:0] == 3'h7;
  endproperty
  a_mul_exit: assert property (p_mul_exit) else $error("multiply exit wrong"); // R13

  property p_fetch;
    (dt_rd.acc[2] || dt_rd.acc[1]) |-> fetch == 11'h020 + {8'h00, dt_rd.acc};
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch dispatch wrong"); // R15

  property p_stop;
    pen_reg && parity_error && !(bus_wr && bus_addr == mas_pkg::OFS_PAR_EN)
      |=> clocks_stopped ##1 clocks_stopped || $past(bus_wr);
  endproperty
  a_stop: assert property (p_stop) else $error("parity stop missed"); // R18

  property p_reset_par;
    disable iff (1'b0) $rose(rst_n) |-> dsp_reg == 5'h00 && !parity_error;
  endproperty
  a_reset_par: assert property (p_reset_par) else $error("reset parity not odd"); // R19

  property p_push;
    push |=> stk_reg[0] == $past(loc_reg) && stk_reg[1] == $past(stk_reg[0]);
  endproperty
  a_push: assert property (p_push) else $error("stack push wrong"); // R21

  property p_effective_address_modify_dispatch;
    st_reg == mas_pkg::MAS_RUN && dsp_reg == mas_pkg::DISP_EAMOD
      |-> (!cond_in.ext_bit13 || addr[1]) && (!cond_in.index_nonzero || addr[0]);
  endproperty
  a_effective_address_modify_dispatch: assert property (p_effective_address_modify_dispatch) else $error("address modify bits lost"); // R7

  property p_mul_step;
    st_reg == mas_pkg::MAS_RUN && dsp_reg == mas_pkg::DISP_MUL && cond_in.exp_sign
      |-> (!cond_in.multiplier_quotient_bit_34 || addr[1]) && (!cond_in.mq35 || addr[0]);
  endproperty
  a_mul_step: assert property (p_mul_step) else $error("multiply step branch wrong"); // R12

  property p_fetch_plain;
    !(dt_rd.acc[2] || dt_rd.acc[1])
      |-> fetch[9:6] == dt_rd.jump[9:6] && fetch[3:0] == dt_rd.jump[3:0];
  endproperty
  a_fetch_plain: assert property (p_fetch_plain) else $error("fetch copy wrong"); // R14

  property p_fetch_sel;
    st_reg == mas_pkg::MAS_RUN && dsp_reg == mas_pkg::DISP_FETCH |-> (addr & fetch) == fetch;
  endproperty
  a_fetch_sel: assert property (p_fetch_sel) else $error("fetch not selected"); // R16

  property p_skip_or;
    skip10 |-> addr[0];
  endproperty
  a_skip_or: assert property (p_skip_or) else $error("skip bit not set"); // R5

  property p_ret;
    st_reg == mas_pkg::MAS_RUN && uw_reg.ret |-> (addr & stk_reg[0]) == stk_reg[0];
  endproperty
  a_ret: assert property (p_ret) else $error("return address lost"); // R22

  property p_pop;
    load && uw_reg.ret && !push |=> stk_reg[0] == $past(stk_reg[1]);
  endproperty
  a_pop: assert property (p_pop) else $error("stack pop wrong"); // R21

  property p_force_push;
    forced_subroutine_push |-> push && microword_load_clock;
  endproperty
  a_force_push: assert property (p_force_push) else $error("forced push missing"); // R10

  property p_jump_only;
    st_reg == mas_pkg::MAS_RUN && dsp_reg != mas_pkg::DISP_DIAG
      && dsp_reg != mas_pkg::DISP_FETCH && dsp_reg != mas_pkg::DISP_EAMOD
      && dsp_reg != mas_pkg::DISP_MUL && !uw_reg.ret && !skip10 |-> addr == uw_reg.jump;
  endproperty
  a_jump_only: assert property (p_jump_only) else $error("jump field not followed"); // R23

  property p_par_odd;
    (^{dispatch_parity, dsp_reg}) == 1'b1;
  endproperty
  a_par_odd: assert property (p_par_odd) else $error("dispatch parity not odd"); // R17

  property p_stop_hold;
    st_reg == mas_pkg::MAS_RUN && clocks_stopped |-> !microword_load_clock;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("load while stopped"); // R18
endmodule : mas_top

// ==== bench/mas_store_model.sv ====
// microword store model standing on the far side of the sequencer
`timescale 1ns/1ps
module mas_store_model (
  input  wire logic [0:10]        microaddress_lines,
  output      mas_pkg::mas_word_t store_word
);
  // ********************
  // storage
  // ********************
  mas_pkg::mas_word_t mem [0:2047];

  // zeroed so a stray address never feeds unknowns back
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = '0;
    end
  end

  assign store_word = mem[microaddress_lines];
endmodule : mas_store_model

// ==== bench/mas_top_bench.sv ====
// self-checking bench of the microprogram address sequencer
`timescale 1ns/1ps
module mas_top_bench;
  // ********************
  // signals
  // ********************
  logic               mclk, rst_n, bus_wr, bus_rd, clock_advance, page_fail;
  logic [7:0]         bus_addr;
  logic [15:0]        bus_wdata, bus_rdata;
  logic [8:0]         opcode;
  logic [0:10]        microaddress_lines;
  logic               microword_load_clock, forced_subroutine_push, reset_parity_override;
  logic               dispatch_parity, parity_error, clocks_stopped;
  mas_pkg::mas_word_t store_word;
  mas_pkg::mas_cond_t cond_in;
  int                 mismatches, n_compared;
  logic [1:0]         e;
  logic [2:0]         acc_tab [4];
  logic [10:0]        fetch_exp [4];

  mas_top mas_top_inst (.mclk(mclk), .rst_n(rst_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .clock_advance(clock_advance), .page_fail(page_fail), .opcode(opcode),
    .store_word(store_word), .cond_in(cond_in), .microaddress_lines(microaddress_lines),
    .microword_load_clock(microword_load_clock),
    .forced_subroutine_push(forced_subroutine_push),
    .reset_parity_override(reset_parity_override), .dispatch_parity(dispatch_parity),
    .parity_error(parity_error), .clocks_stopped(clocks_stopped));

  mas_store_model mas_store_model_inst (.microaddress_lines(microaddress_lines),
    .store_word(store_word));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ********************
  // tasks
  // ********************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge mclk);
    bus_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1;
    chk(bus_rdata, x);
    @(posedge mclk);
  endtask : rd

  task automatic rst(input int n, input logic [10:0] diag);
    rst_n <= 1'b0;
    repeat (n) @(posedge mclk);
    #1;
    chk({13'h0, reset_parity_override, dispatch_parity, parity_error}, 16'h0006);
    chk({5'h00, microaddress_lines}, 16'h0000);
    rst_n <= 1'b1;
    @(posedge mclk);
    wr(mas_pkg::OFS_DIAG_A, {5'h00, diag});
  endtask : rst

  // loads one microword from address a with dispatch code disp
  task automatic setup(input logic [10:0] a, input logic [4:0] disp,
                       input mas_pkg::mas_word_t w);
    rst(2, a);
    wr(mas_pkg::OFS_DSTORE, {11'h000, disp});
    mas_store_model_inst.mem[a] = w;
    clock_advance <= 1'b1;
    #1;
    chk({15'h0, microword_load_clock}, 16'h0001);
    @(posedge mclk);
    clock_advance <= 1'b0;
    #1;
  endtask : setup

  task automatic finish_test;
    if (mismatches == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    finish_test;
  end

  // ********************
  // scenarios
  // ********************
  initial begin
    {rst_n, bus_wr, bus_rd, clock_advance, page_fail} = '0;
    {bus_addr, bus_wdata, opcode} = '0;
    cond_in = '0;
    acc_tab = '{3'h1, 3'h4, 3'h2, 3'h7};
    fetch_exp = '{11'h3cf, 11'h024, 11'h022, 11'h027};
    rst(16, 11'h000);
    wr(mas_pkg::OFS_DIAG_B, 16'h04ff);
    rd(mas_pkg::OFS_DIAG_A, 16'h04ff);
    wr(mas_pkg::OFS_DSTORE, 16'h0015);
    rd(mas_pkg::OFS_DSTORE, 16'h0015);
    wr(mas_pkg::OFS_DTAB, 16'h2abc);
    rd(mas_pkg::OFS_DTAB, 16'h2abc);
    rd(8'h7f, 16'h0000);
    #1;
    chk({5'h00, microaddress_lines}, 16'h04ff);
    wr(mas_pkg::OFS_DIAG_B, 16'h03ff);
    wr(mas_pkg::OFS_DSTORE, 16'h0000);
    wr(mas_pkg::OFS_DIAG_B, 16'h07ff);
    wr(mas_pkg::OFS_DSTORE, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      rst(2, {i[0], 10'h000});
      page_fail <= 1'b1;
      @(posedge mclk);
      page_fail <= 1'b0;
      #1;
      chk({5'h00, microaddress_lines}, {5'h00, i[0], 10'h3ff});
      chk({14'h0, microword_load_clock, forced_subroutine_push}, 16'h0003);
      @(posedge mclk);
      #1;
      chk({14'h0, microword_load_clock, forced_subroutine_push}, 16'h0000);
      chk({5'h00, microaddress_lines}, {5'h00, i[0], 10'h000});
    end
    setup(11'h155, 5'h04, '{jump:11'h2a5, default:'0});
    chk({5'h00, microaddress_lines}, 16'h02a5);
    setup(11'h155, mas_pkg::DISP_EAMOD, '{jump:11'h004, default:'0});
    for (int k = 0; k < 4; k++) begin
      cond_in = '{ext_bit13:k[1], index_nonzero:k[0], default:1'b0};
      #1;
      chk({5'h00, microaddress_lines}, 16'h0004 | k[15:0]);
    end
    for (int s = 0; s < 2; s++) begin
      setup(11'h155, 5'h04, '{jump:11'h100, cond:(s ? 6'h33 : 6'h2b), default:'0});
      for (int t = 0; t < 2; t++) begin
        cond_in = '{skip_true:t[0], default:1'b0};
        #1;
        chk({5'h00, microaddress_lines}, {15'h0080, s[0] & t[0]} >> 0);
      end
    end
    cond_in = '0;
    setup(11'h155, mas_pkg::DISP_MUL, '{default:'0});
    chk({13'h0, microaddress_lines[8:10]}, 16'h0007);
    cond_in <= '{exp_sign:1'b1, multiplier_quotient_bit_34:1'b1, default:1'b0};
    #1;
    chk({13'h0, microaddress_lines[8:10]}, 16'h0002);
    opcode = 9'h0a5;
    wr(mas_pkg::OFS_DIAG_A, 16'h00a5);
    wr(mas_pkg::OFS_DTAB, {2'b00, acc_tab[0], 11'h7ff});
    setup(11'h0a5, mas_pkg::DISP_FETCH, '{default:'0});
    for (int j = 0; j < 4; j++) begin
      wr(mas_pkg::OFS_DTAB, {2'b00, acc_tab[j], 11'h7ff});
      #1;
      chk({5'h00, microaddress_lines}, {5'h00, fetch_exp[j]});
    end
    setup(11'h154, 5'h04, '{jump:11'h200, call:1'b1, default:'0});
    wr(mas_pkg::OFS_DIAG_A, 16'h0200);
    wr(mas_pkg::OFS_DSTORE, 16'h0004);
    mas_store_model_inst.mem[11'h200] = '{jump:11'h001, ret:1'b1, default:'0};
    mas_store_model_inst.mem[11'h155] = '{jump:11'h002, ret:1'b1, default:'0};
    clock_advance <= 1'b1;
    @(posedge mclk);
    #1;
    chk({5'h00, microaddress_lines}, 16'h0155);
    @(posedge mclk);
    clock_advance <= 1'b0;
    #1;
    chk({5'h00, microaddress_lines}, 16'h0002);
    for (int p = 0; p < 2; p++) begin
      setup(11'h155, 5'h04, '{par:p[0], default:'0});
      e[p] = parity_error;
      wr(mas_pkg::OFS_PAR_EN, 16'h0001);
      #1;
      chk({15'h0, clocks_stopped}, {15'h0, e[p]});
      rd(mas_pkg::OFS_STATUS, {3'h0, e[p], e[p], 11'h155});
      if (e[p]) begin
        clock_advance <= 1'b1;
        #1;
        chk({15'h0, microword_load_clock}, 16'h0000);
        @(posedge mclk);
        clock_advance <= 1'b0;
      end
    end
    chk({15'h0, e[0] ^ e[1]}, 16'h0001);
    finish_test;
  end
endmodule : mas_top_bench
